/* design/mioc_params.svh */
// Offsets, field positions, reset values and masks of the config registers
`ifndef MIOC_PARAMS_SVH
`define MIOC_PARAMS_SVH

// Byte addresses of the two registers
`define MIOC_MEM_CFG_ADDR      32'h01f80010
`define MIOC_IO_CFG_ADDR       32'h01f80014

// Reset values: only the PROM write enable comes up set
`define MIOC_MEM_CFG_RST       32'h00010000
`define MIOC_IO_CFG_RST        32'h00000000

// Software-writable bits; reserved bits and the PROM width flag excluded
`define MIOC_MEM_CFG_WMASK     32'h3f1d7fff
`define MIOC_IO_CFG_WMASK      32'h3f3f3f3f

// Memory configuration field positions
`define MIOC_RAM_BLOCKS_LSB    0
`define MIOC_SPARE0_SEL_BIT    2
`define MIOC_SPARE0_TGT_LSB    3
`define MIOC_SPARE1_SEL_BIT    6
`define MIOC_SPARE1_TGT_LSB    7
`define MIOC_RAM_SIZE_LSB      10
`define MIOC_RAM_PARITY_BIT    13
`define MIOC_RAM_EDAC_BIT      14
`define MIOC_PROM_WRITE_BIT    16
`define MIOC_PROM_WIDTH_BIT    17
`define MIOC_PROM_SIZE_LSB     18
`define MIOC_XMEM_SIZE_LSB     24
`define MIOC_XMEM_PARITY_BIT   27
`define MIOC_XMEM_EDAC_BIT     28
`define MIOC_XMEM_PRESENT_BIT  29

// I/O configuration layout: one byte per unit
`define MIOC_IO_UNIT_STRIDE    8
`define MIOC_IO_SIZE_LSB       0
`define MIOC_IO_ENABLE_BIT     4
`define MIOC_IO_PARSRC_BIT     5

// Log2 of the smallest size of each region (size code 0)
`define MIOC_RAM_SIZE_LOG2     5'd18
`define MIOC_PROM_SIZE_LOG2    5'd17
`define MIOC_XMEM_SIZE_LOG2    5'd12
`define MIOC_IO_SIZE_LOG2      5'd9

`endif

/* design/mioc_pkg.sv */
// Types and the size decode shared by the config register block
`default_nettype none
package mioc_pkg;

	// Memory configuration register, bit 31 first
	typedef struct packed {
		logic [1:0] rsvd_hi;
		logic       xmem_present;
		logic       xmem_edac_en;
		logic       xmem_parity_en;
		logic [2:0] xmem_size_code;
		logic [2:0] rsvd_mid;
		logic [2:0] prom_size_code;
		logic       prom_width_flag;
		logic       prom_write_en;
		logic       rsvd_lo;
		logic       ram_edac_en;
		logic       ram_parity_en;
		logic [2:0] ram_size_code;
		logic [2:0] spare_block1_target;
		logic       spare_block1_sel;
		logic [2:0] spare_block0_target;
		logic       spare_block0_sel;
		logic [1:0] ram_block_count;
	} mioc_mem_cfg_s;

	// One I/O unit byte, bits 5..0
	typedef struct packed {
		logic       parity_source;
		logic       enable;
		logic [3:0] size_code;
	} mioc_io_unit_s;

	// Protection controls handed to the parity and EDAC logic
	typedef struct packed {
		logic       ram_parity_gen;
		logic       ram_parity_chk;
		logic       ram_edac;
		logic       prom_parity_gen;
		logic       prom_parity_chk;
		logic       prom_edac;
		logic       xmem_parity_gen;
		logic       xmem_parity_chk;
		logic       xmem_edac;
		logic [3:0] io_parity_gen;
		logic [3:0] io_parity_chk;
	} mioc_prot_s;

	// Region size in bytes: doubling per code step from 2**base
	function automatic logic [31:0] mioc_size_bytes(
		input logic [3:0] code,
		input logic [4:0] base_log2
	);
		logic [4:0] shift;
		shift = base_log2 + {1'b0, code};
		return 32'h00000001 << shift;
	endfunction

endpackage
`default_nettype wire

/* design/mioc_cs_remap.sv */
// RAM chip-select remapping onto the two spare blocks
`timescale 1ns/1ns
`default_nettype none
module mioc_cs_remap
	import mioc_pkg::*;
(
	input  wire mioc_mem_cfg_s cfg_in,
	input  wire logic [7:0]    block_req_in,
	output logic [9:0]         chip_select_out
);

	// Blocks in use by block count: 1, 2, 4 or 8
	logic [7:0] blocks_used;
	logic       spare1_live;
	logic [7:0] replaced0;
	logic [7:0] replaced1;
	logic [7:0] live;

	// Mask of 2**count ones; a shift by 8 clears all, giving 8 blocks
	assign blocks_used = ~(8'hff << (4'h1 << cfg_in.ram_block_count));

	// RULE8 equal targets, second ignored
	assign spare1_live = cfg_in.spare_block1_sel &
		(cfg_in.spare_block1_target != cfg_in.spare_block0_target);

	assign replaced0 = cfg_in.spare_block0_sel ?
		(8'h01 << cfg_in.spare_block0_target) : 8'h00;
	assign replaced1 = spare1_live ?
		(8'h01 << cfg_in.spare_block1_target) : 8'h00;
	assign live      = block_req_in & blocks_used;

	// RULE15 spare replaces target
	assign chip_select_out = {|(live & replaced1), |(live & replaced0),
		live & ~replaced0 & ~replaced1};

endmodule
`default_nettype wire

/* design/mioc_prot_ctl.sv */
// Parity and EDAC control derived from the configuration registers
`timescale 1ns/1ns
`default_nettype none
module mioc_prot_ctl
	import mioc_pkg::*;
(
	input  wire mioc_mem_cfg_s       mem_cfg_in,
	input  wire mioc_io_unit_s [3:0] io_cfg_in,
	input  wire logic                check_allowed_in,
	output mioc_prot_s               prot_out
);

	logic       ram_par;
	logic       xmem_par;
	logic [3:0] io_en;
	logic [3:0] io_src;

	// EDAC always drags parity along with it
	assign ram_par  = mem_cfg_in.ram_parity_en | mem_cfg_in.ram_edac_en;
	// RULE7 EDAC forces parity
	assign xmem_par = mem_cfg_in.xmem_parity_en | mem_cfg_in.xmem_edac_en;

	genvar u;
	generate
		for (u = 0; u < 4; u++) begin : g_unit
			assign io_en[u]  = io_cfg_in[u].enable;
			assign io_src[u] = io_cfg_in[u].parity_source;
		end
	endgenerate

	// Check enables all fall away while checking is inhibited
	assign prot_out.ram_parity_gen  = ram_par;
	// RULE9 inhibit blocks checks
	assign prot_out.ram_parity_chk  = ram_par & check_allowed_in;
	assign prot_out.ram_edac        = mem_cfg_in.ram_edac_en;
	// RULE1 wide PROM: EDAC, parity
	assign prot_out.prom_parity_gen = 1'b1;
	// RULE2 narrow PROM: generate only
	assign prot_out.prom_parity_chk = mem_cfg_in.prom_width_flag &
		check_allowed_in;
	assign prot_out.prom_edac       = mem_cfg_in.prom_width_flag;
	assign prot_out.xmem_parity_gen = xmem_par;
	assign prot_out.xmem_parity_chk = xmem_par & check_allowed_in;
	// RULE6 EDAC only when set
	assign prot_out.xmem_edac       = mem_cfg_in.xmem_edac_en;
	// RULE13 device generates parity
	assign prot_out.io_parity_gen   = io_en & ~io_src;
	// RULE12 unit supplies, device checks
	assign prot_out.io_parity_chk   = io_en & io_src & {4{check_allowed_in}};

endmodule
`default_nettype wire

/* design/mioc_regs.sv */
// Memory and I/O configuration registers with their derived controls
// Contract
// RULE1: Read-only PROM width flag; size code 128K-16M
// RULE2: Flag clear: 8-bit PROM, parity generation only
// RULE3: Width flag loaded from pin at reset
// RULE4: Software writes to width flag ignored
// RULE5: Exchange memory present, size, parity; reset clear
// RULE6: Exchange EDAC only when bit 28 set
// RULE7: Exchange EDAC forces exchange parity on
// RULE8: Equal spare targets: second selector ignored
// RULE9: Parity inhibit input suppresses all parity checks
// RULE10: I/O size code: 512 bytes to 16 Mbytes
// RULE11: Per-unit I/O enables at bits 4,12,20,28
// RULE12: Parity source set: device checks unit parity
// RULE13: Parity source clear: device generates parity
// RULE14: Memory config at 01F80010, next to I/O
// RULE15: Spare block replaces target's chip select
// RULE16: Reserved bits read zero, writes ignored
`timescale 1ns/1ns
`default_nettype none
`include "mioc_params.svh"
module mioc_regs
	import mioc_pkg::*;
(
	input  wire logic                ref_clk_in,
	input  wire logic                resetn_in,
	// Register port
	input  wire logic [31:0]         reg_addr_in,
	input  wire logic [31:0]         reg_wdata_in,
	input  wire logic                reg_wr_in,
	input  wire logic                reg_rd_in,
	output logic [31:0]              reg_rdata_out,
	output logic                     reg_rvalid_out,
	// Pins
	input  wire logic                prom_width_pin_in,
	input  wire logic                parity_check_inhibit_n_in,
	// Block request from the address decoder, same clock
	input  wire logic [7:0]          ram_block_req_in,
	// Configuration and derived controls
	output mioc_mem_cfg_s            mem_cfg_out,
	output mioc_io_unit_s [3:0]      io_cfg_out,
	output mioc_prot_s               prot_out,
	output logic [9:0]               ram_chip_select_out,
	output logic [25:0]              ram_size_bytes_out,
	output logic [24:0]              prom_size_bytes_out,
	output logic [19:0]              xmem_size_bytes_out,
	output logic [3:0][24:0]         io_size_bytes_out
);

	// Stored register bits and flags
	logic [31:0]         mem_cfg_q;
	logic [31:0]         mem_cfg_d;
	logic                prom_width_flag_q;
	logic [31:0]         io_cfg_q;
	logic [31:0]         io_cfg_d;
	logic [31:0]         rdata_q;
	logic [31:0]         rdata_d;
	logic                rvalid_q;

	// Pin synchronisers
	logic                width_meta_q;
	logic                width_sync_q;
	logic                inhibit_meta_q;
	logic                inhibit_sync_q;

	// Registered outputs
	mioc_prot_s          prot_q;
	mioc_prot_s          prot_d;
	logic [9:0]          cs_q;
	logic [9:0]          cs_d;
	logic [25:0]         ram_size_q;
	logic [24:0]         prom_size_q;
	logic [19:0]         xmem_size_q;
	logic [3:0][24:0]    io_size_q;
	logic [3:0][24:0]    io_size_d;

	// Decode and views
	logic                hit_mem;
	logic                hit_io;
	logic                wr_mem;
	logic                wr_io;
	logic [31:0]         mem_view;
	mioc_mem_cfg_s       mem_cfg;
	mioc_io_unit_s [3:0] io_cfg;
	logic [31:0]         ram_size_w;
	logic [31:0]         prom_size_w;
	logic [31:0]         xmem_size_w;

	// Address decode; anything else reads as zero
	// RULE14 memory config address
	assign hit_mem = (reg_addr_in == `MIOC_MEM_CFG_ADDR);
	assign hit_io  = (reg_addr_in == `MIOC_IO_CFG_ADDR);
	assign wr_mem  = reg_wr_in & hit_mem;
	assign wr_io   = reg_wr_in & hit_io;

	// Merge writes under the mask so reserved bits never store
	// RULE16 reserved bits stay zero
	assign mem_cfg_d = wr_mem ?
		(reg_wdata_in & `MIOC_MEM_CFG_WMASK) : mem_cfg_q;
	assign io_cfg_d  = wr_io ?
		(reg_wdata_in & `MIOC_IO_CFG_WMASK) : io_cfg_q;

	// Width flag is spliced in from its own flop
	// RULE4 write to flag dropped
	assign mem_view = {mem_cfg_q[31:`MIOC_PROM_WIDTH_BIT + 1],
		prom_width_flag_q, mem_cfg_q[`MIOC_PROM_WIDTH_BIT - 1:0]};
	assign mem_cfg  = mioc_mem_cfg_s'(mem_view);

	// Unpack the I/O units, one byte each
	// RULE11 per-unit enable bits
	genvar u;
	generate
		for (u = 0; u < 4; u++) begin : g_io
			assign io_cfg[u] = mioc_io_unit_s'(
				io_cfg_q[u * `MIOC_IO_UNIT_STRIDE +: 6]);
			// RULE10 512 bytes doubling
			assign io_size_d[u] = 25'(mioc_size_bytes(
				io_cfg[u].size_code, `MIOC_IO_SIZE_LOG2));
		end
	endgenerate

	// Region sizes in bytes for the address decoder
	assign ram_size_w  = mioc_size_bytes({1'b0, mem_cfg.ram_size_code},
		`MIOC_RAM_SIZE_LOG2);
	// RULE1 PROM size from code
	assign prom_size_w = mioc_size_bytes({1'b0, mem_cfg.prom_size_code},
		`MIOC_PROM_SIZE_LOG2);
	// RULE5 exchange memory size
	assign xmem_size_w = mioc_size_bytes({1'b0, mem_cfg.xmem_size_code},
		`MIOC_XMEM_SIZE_LOG2);

	// Read mux; data only in the cycle after the strobe
	assign rdata_d = !reg_rd_in ? 32'h00000000 :
		hit_mem ? mem_view :
		hit_io  ? io_cfg_q : 32'h00000000;

	// Chip-select remap on the stored configuration
	mioc_cs_remap u_cs_remap (
		.cfg_in          (mem_cfg),
		.block_req_in    (ram_block_req_in),
		.chip_select_out (cs_d)
	);

	// Parity and EDAC controls; inhibit pin is active low
	mioc_prot_ctl u_prot_ctl (
		.mem_cfg_in       (mem_cfg),
		.io_cfg_in        (io_cfg),
		.check_allowed_in (inhibit_sync_q),
		.prot_out         (prot_d)
	);

	// Pin synchronisers; no reset so the width pin is seen during reset
	always_ff @(posedge ref_clk_in) begin
		width_meta_q   <= prom_width_pin_in;
		width_sync_q   <= width_meta_q;
		inhibit_meta_q <= parity_check_inhibit_n_in;
		inhibit_sync_q <= inhibit_meta_q;
	end

	// Width flag follows the synchronised pin while reset is held
	// RULE3 capture pin at reset
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			prom_width_flag_q <= width_sync_q;
		end
	end

	// Configuration registers
	// RULE5 exchange settings reset clear
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			mem_cfg_q <= `MIOC_MEM_CFG_RST;
			io_cfg_q  <= `MIOC_IO_CFG_RST;
		end else begin
			mem_cfg_q <= mem_cfg_d;
			io_cfg_q  <= io_cfg_d;
		end
	end

	// Read data port
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			rdata_q  <= 32'h00000000;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= reg_rd_in;
		end
	end

	// Derived controls registered so every output leaves a flop;
	// costs one cycle after a register write
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			prot_q      <= '0;
			cs_q        <= 10'h000;
			ram_size_q  <= 26'h0000000;
			prom_size_q <= 25'h0000000;
			xmem_size_q <= 20'h00000;
			io_size_q   <= '0;
		end else begin
			prot_q      <= prot_d;
			cs_q        <= cs_d;
			ram_size_q  <= ram_size_w[25:0];
			prom_size_q <= prom_size_w[24:0];
			xmem_size_q <= xmem_size_w[19:0];
			io_size_q   <= io_size_d;
		end
	end

	// Output drive
	assign reg_rdata_out       = rdata_q;
	assign reg_rvalid_out      = rvalid_q;
	assign mem_cfg_out         = mem_cfg;
	assign io_cfg_out          = io_cfg;
	assign prot_out            = prot_q;
	assign ram_chip_select_out = cs_q;
	assign ram_size_bytes_out  = ram_size_q;
	assign prom_size_bytes_out = prom_size_q;
	assign xmem_size_bytes_out = xmem_size_q;
	assign io_size_bytes_out   = io_size_q;

endmodule
`default_nettype wire

/* sim/mioc_regs_assertions.sv */
// Concurrent checks on the config register block ports
`timescale 1ns/1ns
`default_nettype none
`include "mioc_params.svh"
module mioc_regs_chk
	import mioc_pkg::*;
(
	input wire logic                ref_clk_in,
	input wire logic                resetn_in,
	input wire logic [31:0]         reg_addr_in,
	input wire logic [31:0]         reg_wdata_in,
	input wire logic                reg_wr_in,
	input wire logic                reg_rd_in,
	input wire logic [31:0]         reg_rdata_out,
	input wire logic                reg_rvalid_out,
	input wire logic                parity_check_inhibit_n_in,
	input wire mioc_mem_cfg_s       mem_cfg_out,
	input wire mioc_io_unit_s [3:0] io_cfg_out,
	input wire mioc_prot_s          prot_out,
	input wire logic [9:0]          ram_chip_select_out,
	input wire logic [24:0]         prom_size_bytes_out,
	input wire logic [19:0]         xmem_size_bytes_out,
	input wire logic [3:0][24:0]    io_size_bytes_out
);
	logic [3:0] en_v;
	logic [3:0] src_v;
	logic       run_q;
	// Unit enables and parity sources as vectors
	assign en_v = {io_cfg_out[3].enable, io_cfg_out[2].enable,
		io_cfg_out[1].enable, io_cfg_out[0].enable};
	assign src_v = {io_cfg_out[3].parity_source, io_cfg_out[2].parity_source,
		io_cfg_out[1].parity_source, io_cfg_out[0].parity_source};
	// Skips the first edge after reset, where outputs still settle
	always_ff @(posedge ref_clk_in) begin
		run_q <= resetn_in;
	end
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	// Inhibit held through both sync stages and the output flop
	sequence s_inhib;
		!parity_check_inhibit_n_in [*3];
	endsequence
	AST_RVALID: assert property (run_q |-> reg_rvalid_out == $past(reg_rd_in))
		else $error("read valid not one cycle after read");
	AST_MEM_WR: assert property (reg_wr_in &&
		reg_addr_in == `MIOC_MEM_CFG_ADDR |=> mem_cfg_out.xmem_size_code
		== $past(reg_wdata_in[26:24])) else $error("memory config write lost");
	AST_WIDTH_RO: assert property (run_q |->
		$stable(mem_cfg_out.prom_width_flag)) else $error("width flag moved");
	AST_RSVD: assert property (reg_rd_in &&
		reg_addr_in == `MIOC_IO_CFG_ADDR |=> !(reg_rdata_out & 32'hc0c0c0c0))
		else $error("reserved io bits read nonzero");
	AST_XMEM_EDAC: assert property (run_q && prot_out.xmem_edac |->
		$past(mem_cfg_out.xmem_edac_en)) else $error("edac without enable");
	AST_XMEM_PAR: assert property (run_q &&
		$past(mem_cfg_out.xmem_edac_en) |-> prot_out.xmem_parity_gen)
		else $error("edac without parity");
	AST_PROM_WIDTH_PIN: assert property (!mem_cfg_out.prom_width_flag |->
		!prot_out.prom_edac && !prot_out.prom_parity_chk)
		else $error("narrow prom checked");
	AST_INHIBIT: assert property (s_inhib |=> !(prot_out.ram_parity_chk |
		prot_out.prom_parity_chk | prot_out.xmem_parity_chk |
		(|prot_out.io_parity_chk))) else $error("check while inhibited");
	AST_IO_WR: assert property (reg_wr_in &&
		reg_addr_in == `MIOC_IO_CFG_ADDR |=> io_cfg_out ==
		$past({reg_wdata_in[29:24], reg_wdata_in[21:16],
		reg_wdata_in[13:8], reg_wdata_in[5:0]})) else $error("io write lost");
	AST_IO_GEN: assert property (run_q |-> prot_out.io_parity_gen ==
		($past(en_v) & ~$past(src_v))) else $error("io parity gen wrong");
	AST_IO_SIZE: assert property (run_q |-> io_size_bytes_out[3] ==
		25'h200 << $past(io_cfg_out[3].size_code)) else $error("io size");
	AST_XMEM_SIZE: assert property (run_q |-> xmem_size_bytes_out ==
		20'h1000 << $past(mem_cfg_out.xmem_size_code)) else $error("xmem size");
	AST_SPARE0: assert property (run_q &&
		$past(mem_cfg_out.spare_block0_sel) |-> !ram_chip_select_out
		[$past(mem_cfg_out.spare_block0_target)]) else $error("replaced cs on");
	AST_SPARE_EQ: assert property (run_q &&
		$past(mem_cfg_out.spare_block0_target) ==
		$past(mem_cfg_out.spare_block1_target) |-> !ram_chip_select_out[9])
		else $error("second spare used with equal targets");
endmodule
bind mioc_regs mioc_regs_chk mioc_regs_chk_i (.ref_clk_in, .resetn_in,
	.reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
	.reg_rvalid_out, .parity_check_inhibit_n_in, .mem_cfg_out, .io_cfg_out,
	.prot_out, .ram_chip_select_out, .prom_size_bytes_out,
	.xmem_size_bytes_out, .io_size_bytes_out);
`default_nettype wire

/* sim/mioc_regs_bench.sv */
// Self-checking bench of the config register block
`timescale 1ns/1ns
`default_nettype none
`include "mioc_params.svh"
module mioc_regs_bench
	import mioc_pkg::*;
;
	localparam logic [31:0] MEM_A = `MIOC_MEM_CFG_ADDR;
	localparam logic [31:0] IO_A = `MIOC_IO_CFG_ADDR;
	logic                clk, rst_n, wr, rd, pin, inh_n, rvalid;
	logic [31:0]         addr, wdata, rdata, seed;
	logic [7:0]          req;
	mioc_mem_cfg_s       mcfg;
	mioc_io_unit_s [3:0] iocfg;
	mioc_prot_s          prot;
	logic [9:0]          cs;
	logic [25:0]         rsz;
	logic [24:0]         psz;
	logic [19:0]         xsz;
	logic [3:0][24:0]    iosz;
	int                  mismatches, samples_checked, cycles;
	mioc_regs mioc_regs_i (.ref_clk_in(clk), .resetn_in(rst_n),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
		.reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
		.prom_width_pin_in(pin), .parity_check_inhibit_n_in(inh_n),
		.ram_block_req_in(req), .mem_cfg_out(mcfg), .io_cfg_out(iocfg),
		.prot_out(prot), .ram_chip_select_out(cs), .ram_size_bytes_out(rsz),
		.prom_size_bytes_out(psz), .xmem_size_bytes_out(xsz),
		.io_size_bytes_out(iosz));
	// 50 ns period
	always #25 clk = ~clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Enabled units whose parity source equals s
	function automatic logic [3:0] par_exp(input logic [31:0] v, input logic s);
		for (int u = 0; u < 4; u++)
			par_exp[u] = v[8*u+4] & (v[8*u+5] == s);
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic bus_wr(input logic [31:0] a, v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [31:0] a, exp, input string nm);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(nm, rdata, exp);
	endtask
	// Pin held from the start of reset so both sync stages see it
	task automatic do_reset(input logic p);
		@(posedge clk);
		rst_n <= 1'b0;
		pin <= p;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		tick(2);
	endtask
	task automatic complete_run;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			complete_run;
		end
	end
	initial begin
		clk = 0;
		rst_n = 0;
		wr = 0;
		rd = 0;
		pin = 1;
		inh_n = 1;
		addr = 0;
		wdata = 0;
		req = 0;
		seed = 32'h15;
		mismatches = 0;
		samples_checked = 0;
		cycles = 0;
		do_reset(1'b1);
		bus_rd(MEM_A, 32'h00030000, "mem reset");
		bus_rd(IO_A, 32'h0, "io reset");
		chk("prom edac", prot.prom_edac, 1'b1);
		bus_wr(MEM_A, 32'hffffffff);
		bus_rd(MEM_A, `MIOC_MEM_CFG_WMASK | 32'h00020000, "mem ones");
		bus_wr(MEM_A, 32'h0);
		bus_rd(MEM_A, 32'h00020000, "mem zero");
		bus_wr(IO_A, 32'hffffffff);
		bus_rd(IO_A, 32'h3f3f3f3f, "io ones");
		bus_wr(32'h01f80018, 32'hffffffff);
		bus_rd(32'h01f80018, 32'h0, "unmapped");
		bus_rd(MEM_A, 32'h00020000, "mem kept");
		// Random field values across both registers
		for (int i = 0; i < 24; i++) begin
			seed = lfsr(seed);
			bus_wr(IO_A, seed);
			bus_rd(IO_A, seed & 32'h3f3f3f3f, "io rand");
			tick(1);
			chk("io size", iosz[i%4], 25'h200 << seed[8*(i%4)+:4]);
			chk("io gen", prot.io_parity_gen, par_exp(seed, 1'b0));
			chk("io chk", prot.io_parity_chk, par_exp(seed, 1'b1));
			seed = lfsr(seed);
			bus_wr(MEM_A, seed);
			tick(1);
			chk("prom size", psz, 25'h20000 << seed[20:18]);
			chk("xmem size", xsz, 20'h1000 << seed[26:24]);
			chk("xmem edac", prot.xmem_edac, seed[28]);
			chk("xmem par", prot.xmem_parity_gen, seed[28] | seed[27]);
			chk("ram size", rsz, 26'h0040000 << seed[12:10]);
			chk("ram chk", prot.ram_parity_chk, seed[14] | seed[13]);
		end
		@(posedge clk);
		inh_n <= 1'b0;
		bus_wr(MEM_A, 32'h08000000);
		bus_wr(IO_A, 32'h00000030);
		tick(4);
		chk("inhibit", {prot.xmem_parity_chk, prot.io_parity_chk}, 5'h0);
		@(posedge clk);
		inh_n <= 1'b1;
		tick(5);
		chk("checks", {prot.xmem_parity_chk, prot.io_parity_chk}, 5'h11);
		// Spare targets equal, then apart, then equal with spare0 off
		bus_wr(MEM_A, 32'h00000157);
		@(posedge clk);
		req <= 8'h04;
		tick(1);
		chk("cs equal", cs, 10'h100);
		bus_wr(MEM_A, 32'h000002d7);
		@(posedge clk);
		req <= 8'h20;
		tick(1);
		chk("cs spare1", cs, 10'h200);
		bus_wr(MEM_A, 32'h000002eb);
		tick(2);
		chk("cs ignored", cs, 10'h020);
		// Four blocks only: block 5 gives no select, block 3 does
		bus_wr(MEM_A, 32'h00000002);
		tick(2);
		chk("cs count", cs, 10'h000);
		@(posedge clk);
		req <= 8'h08;
		tick(1);
		chk("cs block3", cs, 10'h008);
		do_reset(1'b0);
		chk("flag", mcfg.prom_width_flag, 1'b0);
		chk("prom_width_pin", {prot.prom_edac, prot.prom_parity_chk,
			prot.prom_parity_gen}, 3'b001);
		complete_run;
	end
endmodule
`default_nettype wire
